// file: shared/dpis_cfg.svh
/*
  Constants for the power-up and power-fail sequencer: timing figures and counts.
  Assumes a 20 MHz core clock; included by the loader and sequencer modules by bare name.
*/
`ifndef DPIS_CFG_SVH
`define DPIS_CFG_SVH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define DPIS_CLK_HZ          20000000
`define DPIS_PARK_TIME_US    500
// longest time rounds down: the park must finish inside the warning window
`define DPIS_PARK_CYCLES     ((`DPIS_PARK_TIME_US * (`DPIS_CLK_HZ / 1000000)))
`define DPIS_PLL_WAIT_CYC    64
`define DPIS_CFG_WORDS       256
`define DPIS_CNT_W           16

`endif

// file: shared/dpis_pkg.sv
/*
  Types for the power-up and power-fail sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dpis_pkg;

  // ----------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    DPIS_ST_PLL    = 6'h01,
    DPIS_ST_LOAD   = 6'h02,
    DPIS_ST_RUN    = 6'h04,
    DPIS_ST_PARK   = 6'h08,
    DPIS_ST_PARKED = 6'h10,
    DPIS_ST_IDLE   = 6'h20
  } dpis_state_t;

endpackage

// file: verilog/dpis_flash_loader.sv
/*
  Flash configuration loader: reads a fixed number of words from serial flash.
  Assumes mode-0 serial flash answering a read command; one bit per two clocks.
*/
`timescale 1ns/10ps
`include "dpis_cfg.svh"

module dpis_flash_loader (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_start,
  input  wire logic        i_miso,
  output logic             o_sclk,
  output logic             o_mosi,
  output logic             o_csn,
  output logic             o_done
);

  // ----------------------------------------------------------------
  // bit engine: 8 command bits, 24 address bits, then data words
  // ----------------------------------------------------------------
  localparam logic [31:0] READ_HDR = 32'h03000000;
  localparam int          TOTAL    = 32 + 8 * `DPIS_CFG_WORDS;

  logic        busy_reg;
  logic        phase_reg;
  logic [15:0] bit_reg;
  logic [31:0] shift_reg;
  logic [7:0]  data_reg;

  // toggle clock each cycle; shift on falling edge, sample on rising
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_reg  <= 1'b0;
      phase_reg <= 1'b0;
      bit_reg   <= 16'h0000;
      shift_reg <= 32'h00000000;
      data_reg  <= 8'h00;
      o_done    <= 1'b0;
    end else if (i_start && !busy_reg && !o_done) begin
      busy_reg  <= 1'b1;
      shift_reg <= READ_HDR;
      bit_reg   <= 16'h0000;
    end else if (busy_reg) begin
      phase_reg <= ~phase_reg;
      if (!phase_reg) begin
        data_reg <= {data_reg[6:0], i_miso};
      end else begin
        shift_reg <= {shift_reg[30:0], 1'b0};
        bit_reg   <= bit_reg + 16'h0001;
        if (bit_reg == 16'(TOTAL - 1)) begin
          busy_reg <= 1'b0;
          o_done   <= 1'b1;
        end
      end
    end
  end

  assign o_sclk = busy_reg & phase_reg;
  assign o_mosi = shift_reg[31];
  assign o_csn  = ~busy_reg;

endmodule

// file: verilog/dpis_sequencer.sv
/*
  Power-up initialisation and power-fail park sequencer of the display controller.
  Assumes a 20 MHz reference clock that runs throughout, a monitor that drives reset
  and the power-good warning, and a PLL and mirror array that report lock and park done.
*/
// Function
// - during reset outputs are inactive and bidirectional pins are inputs; o_pll_enable is tied high, so it stays active through reset.
// - during reset mirror power, LED controls and flash pins are tri-stated.
// - after reset, lock PLL first, then load configuration from serial flash.
// - on reset release all I/O pins become active.
// - init-done output goes high right after reset release.
// - init-done output goes low when auto-initialisation completes.
// - power-good low makes the device park the mirror array; the code parks only on a power-good fall seen in PLL, LOAD or RUN.
`timescale 1ns/10ps
`include "dpis_cfg.svh"

module dpis_sequencer (
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  input  wire logic                  i_power_good,
  input  wire logic                  i_pll_locked,
  input  wire logic                  i_park_done,
  input  wire logic                  i_flash_miso,
  input  wire logic                  i_gpio_in,
  output logic                       o_pll_enable,
  output logic                       o_init_done_output,
  output logic                       o_init_done_output_oen,
  output logic                       o_mirror_array_power_enable,
  output logic                       o_mirror_array_power_enable_oen,
  output logic                       o_led_driver_on,
  output logic                       o_led_driver_on_oen,
  output logic [1:0]                 o_led_select,
  output logic [1:0]                 o_led_select_oen,
  output logic                       o_serial_flash_clock,
  output logic                       o_serial_flash_clock_oen,
  output logic                       o_serial_data_out,
  output logic                       o_serial_data_out_oen,
  output logic                       o_chip_select_zero,
  output logic                       o_chip_select_zero_oen,
  output logic                       o_park_request,
  output dpis_pkg::dpis_state_t      o_state
);
  import dpis_pkg::*;

  // ----------------------------------------------------------------
  // state and counters
  // ----------------------------------------------------------------
  localparam logic [15:0] PARK_CYC = 16'(`DPIS_PARK_CYCLES);
  localparam logic [15:0] PLL_CYC  = 16'(`DPIS_PLL_WAIT_CYC);

  dpis_state_t state_reg;
  dpis_state_t state_next;
  logic [15:0] pll_cnt_reg;
  logic [15:0] park_cnt_reg;
  logic        init_busy_reg;
  logic        active_reg;
  logic        pg_prev_reg;
  logic        load_start;
  logic        load_done;
  logic        flash_sclk;
  logic        flash_mosi;
  logic        flash_csn;
  logic        pg_fall;

  assign pg_fall = pg_prev_reg & ~i_power_good;

  // ----------------------------------------------------------------
  // flash loader
  // ----------------------------------------------------------------
  dpis_flash_loader u_loader (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_start  (load_start),
    .i_miso   (i_flash_miso),
    .o_sclk   (flash_sclk),
    .o_mosi   (flash_mosi),
    .o_csn    (flash_csn),
    .o_done   (load_done)
  );

  // ----------------------------------------------------------------
  // next state: warning beats any init step, since the supply is going
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DPIS_ST_PLL: begin
        if (pg_fall) begin
          state_next = DPIS_ST_PARK;
        end else if (i_pll_locked && pll_cnt_reg >= PLL_CYC) begin
          state_next = DPIS_ST_LOAD;
        end
      end
      DPIS_ST_LOAD: begin
        if (pg_fall) begin
          state_next = DPIS_ST_PARK;
        end else if (load_done) begin
          state_next = DPIS_ST_RUN;
        end
      end
      DPIS_ST_RUN: begin
        if (pg_fall) begin
          state_next = DPIS_ST_PARK;
        end
      end
      DPIS_ST_PARK: begin
        if (i_park_done || park_cnt_reg == PARK_CYC) begin
          state_next = DPIS_ST_PARKED;
        end
      end
      DPIS_ST_PARKED: state_next = DPIS_ST_PARKED;
      DPIS_ST_IDLE:   state_next = DPIS_ST_PLL;
      default:        state_next = DPIS_ST_IDLE;
    endcase
  end

  // state register; idle for one edge after reset release
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= DPIS_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // power-good edge detect, reset value high so no false fall
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pg_prev_reg <= 1'b1;
    end else begin
      pg_prev_reg <= i_power_good;
    end
  end

  // pll settle counter, held at its top
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pll_cnt_reg <= 16'h0000;
    end else if (state_reg == DPIS_ST_PLL && pll_cnt_reg < PLL_CYC) begin
      pll_cnt_reg <= pll_cnt_reg + 16'h0001;
    end
  end

  // park window counter; bounded by the warning lead time
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      park_cnt_reg <= 16'h0000;
    end else if (state_reg == DPIS_ST_PARK && park_cnt_reg < PARK_CYC) begin
      park_cnt_reg <= park_cnt_reg + 16'h0001;
    end
  end

  // init busy flag: loaded high by reset, cleared once, never set again
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      init_busy_reg <= 1'b1;
    end else if (state_reg == DPIS_ST_LOAD && load_done) begin
      init_busy_reg <= 1'b0;
    end else if (state_reg == DPIS_ST_RUN) begin
      init_busy_reg <= 1'b0;
    end
  end

  // pins come alive at the first edge after release
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= 1'b1;
    end
  end

  assign load_start   = (state_reg == DPIS_ST_LOAD);
  assign o_pll_enable = 1'b1;
  assign o_state      = state_reg;
  // warning abort in PLL, or in LOAD before load_done, leaves init-done high; a warning that meets load_done still clears it
  assign o_park_request = (state_reg == DPIS_ST_PARK);

  // ----------------------------------------------------------------
  // pin drive; enables are low while driving
  // ----------------------------------------------------------------
  // init-done is a gpio: an input while reset holds, so no contention
  assign o_init_done_output     = init_busy_reg & active_reg;
  assign o_init_done_output_oen = ~active_reg;
  // mirror power drops once parked so the array is left safe
  assign o_mirror_array_power_enable     = active_reg & (state_reg != DPIS_ST_PARKED);
  assign o_mirror_array_power_enable_oen = ~active_reg;
  assign o_led_driver_on     = active_reg & (state_reg == DPIS_ST_RUN);
  assign o_led_driver_on_oen = ~active_reg;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_led_sel
      assign o_led_select[g]     = 1'b0;
      assign o_led_select_oen[g] = ~active_reg;
    end
  endgenerate

  assign o_serial_flash_clock     = flash_sclk;
  assign o_serial_flash_clock_oen = ~active_reg;
  assign o_serial_data_out        = flash_mosi;
  assign o_serial_data_out_oen    = ~active_reg;
  assign o_chip_select_zero       = flash_csn;
  assign o_chip_select_zero_oen   = ~active_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_tristate_in_reset: assert property (@(posedge i_clk) !i_resetn |->
    (o_led_driver_on_oen && o_chip_select_zero_oen && o_mirror_array_power_enable_oen))
    else $error("pin driven during reset");
  chk_pins_active: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $past(i_resetn) |-> !o_serial_flash_clock_oen && !o_init_done_output_oen)
    else $error("pins not active after reset");
  chk_done_high_early: assert property (@(posedge i_clk) disable iff (!i_resetn)
    state_reg == DPIS_ST_PLL |-> o_init_done_output)
    else $error("init-done low during pll lock");
  chk_pll_before_load: assert property (@(posedge i_clk) disable iff (!i_resetn)
    state_reg == DPIS_ST_LOAD |-> pll_cnt_reg == PLL_CYC)
    else $error("flash load before pll settle");
  chk_done_falls: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_reg == DPIS_ST_LOAD && load_done && !pg_fall) |=> !o_init_done_output)
    else $error("init-done not cleared at completion");
  chk_done_stays_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !o_init_done_output && active_reg |=> !o_init_done_output)
    else $error("init-done rose again");
  chk_park_on_warn: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (pg_fall && state_reg == DPIS_ST_RUN) |=> o_park_request)
    else $error("no park on warning");
  // the park counter is the helper: once it reaches the window end, park must be over
  chk_park_bounded: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (state_reg == DPIS_ST_PARK && park_cnt_reg == PARK_CYC) |=> state_reg == DPIS_ST_PARKED)
    else $error("park not finished in window");

endmodule

// file: tb/dpis_far_side.sv
/*
  Far-side model of the sequencer: PLL lock, mirror park report and serial flash data.
  Assumes the testbench clock; every output changes on the falling clock edge.
*/
`timescale 1ns/10ps

module dpis_far_side (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_pll_enable,
  input  wire logic        i_park_request,
  input  wire logic        i_sclk,
  input  wire logic        i_csn,
  input  wire logic [7:0]  i_lock_delay,
  input  wire logic [15:0] i_park_delay,
  output logic             o_pll_locked,
  output logic             o_park_done,
  output logic             o_miso
);
  int         lock_cnt;
  int         park_cnt;
  logic       sclk_d;
  logic [3:0] bits;

  // ----------------------------------------------------------------
  // lock, park and flash data
  // ----------------------------------------------------------------
  // a park delay of ffff never reports done, so the window has to run out
  always @(negedge i_clk) begin
    sclk_d <= i_sclk;
    if (i_resetn !== 1'b1) begin
      lock_cnt <= 0;
      park_cnt <= 0;
      o_pll_locked <= 1'b0;
      o_park_done <= 1'b0;
      o_miso <= 1'b0;
      bits <= 4'h0;
    end else begin
      if (i_pll_enable === 1'b1) begin
        lock_cnt <= lock_cnt + 1;
      end
      o_pll_locked <= (lock_cnt >= int'(i_lock_delay));
      if (i_park_request === 1'b1) begin
        park_cnt <= park_cnt + 1;
      end
      o_park_done <= (i_park_delay != 16'hffff) && (park_cnt >= int'(i_park_delay));
      // unselected flash line wanders every cycle, selected data moves on falling sclk
      if (i_csn !== 1'b0) begin
        o_miso <= ~o_miso;
      end else if (sclk_d === 1'b1 && i_sclk === 1'b0) begin
        bits <= bits + 4'h1;
        o_miso <= bits[0] ^ bits[3];
      end
    end
  end
endmodule

// file: tb/tb.sv
/*
  Testbench of the power-up and power-fail sequencer; the bench plays the power monitor.
  Assumes dpis_far_side as PLL, mirror and flash; pad of init-done has a pull-down.
*/
`timescale 1ns/10ps

module tb;
  import dpis_pkg::*;

  // ----------------------------------------------------------------
  // clock, wiring and bookkeeping
  // ----------------------------------------------------------------
  logic        clk = 1'b1;
  logic        resetn = 1'b1; // first reset call makes a real falling edge
  logic        pg = 1'b1;
  logic [7:0]  lock_dly = 8'h10;
  logic [15:0] park_dly = 16'h0020;
  logic        pll_en, locked, park_done, miso, idn, idn_oen, mpe, mpe_oen, ldo, ldo_oen;
  logic        sclk, sclk_oen, mosi, mosi_oen, csn, csn_oen, park_req, idn_d, req_d, done_seen;
  logic [1:0]  lsel, lsel_oen;
  logic [31:0] hdr;
  dpis_state_t state;
  dpis_state_t q_state[$];
  logic [31:0] q_word[$];
  int          fails = 0;
  int          n_checks = 0;
  int          nbit = 0;
  wire logic [7:0] oens = {idn_oen, mpe_oen, ldo_oen, lsel_oen, sclk_oen, mosi_oen, csn_oen};

  always #25 clk = ~clk;

  dpis_sequencer i_dpis_sequencer (
    .i_clk(clk), .i_resetn(resetn), .i_power_good(pg), .i_pll_locked(locked),
    .i_park_done(park_done), .i_flash_miso(miso), .i_gpio_in(idn_oen ? 1'b0 : idn),
    .o_pll_enable(pll_en), .o_init_done_output(idn), .o_init_done_output_oen(idn_oen),
    .o_mirror_array_power_enable(mpe), .o_mirror_array_power_enable_oen(mpe_oen),
    .o_led_driver_on(ldo), .o_led_driver_on_oen(ldo_oen), .o_led_select(lsel),
    .o_led_select_oen(lsel_oen), .o_serial_flash_clock(sclk), .o_serial_flash_clock_oen(sclk_oen),
    .o_serial_data_out(mosi), .o_serial_data_out_oen(mosi_oen), .o_chip_select_zero(csn),
    .o_chip_select_zero_oen(csn_oen), .o_park_request(park_req), .o_state(state));

  dpis_far_side i_dpis_far_side (
    .i_clk(clk), .i_resetn(resetn), .i_pll_enable(pll_en), .i_park_request(park_req),
    .i_sclk(sclk), .i_csn(csn), .i_lock_delay(lock_dly), .i_park_delay(park_dly),
    .o_pll_locked(locked), .o_park_done(park_done), .o_miso(miso));

  // ----------------------------------------------------------------
  // compares, bounded waits and verdict
  // ----------------------------------------------------------------
  task automatic cmp_state(input dpis_state_t got, input dpis_state_t exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: state got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bits(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // sel 0: init done, 1: parked, 2: park requested
  task automatic wait_for(input int sel, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge clk);
      if ((sel == 0 && idn === 1'b0) || (sel == 1 && state === DPIS_ST_PARKED) ||
          (sel == 2 && park_req === 1'b1)) begin
        return;
      end
    end
    fails++;
    $display("Error at %0t: wait ran out, got %h expected %h", $time, 0, sel);
    results();
  endtask

  // power monitor: hold reset with warning high, then release
  task automatic do_reset;
    resetn = 1'b0;
    pg = 1'b1;
    repeat (6) @(negedge clk);
    cmp_bits(32'(oens), 32'hff);
    q_word.push_back(32'h03000000);
    resetn = 1'b1;
    @(negedge clk);
    cmp_bits(32'({oens, idn}), 32'h001);
  endtask

  // ----------------------------------------------------------------
  // watchers: init-done and park events, flash header
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (resetn !== 1'b1) begin
      done_seen <= 1'b0;
    end else begin
      if (idn_d === 1'b1 && idn === 1'b0) begin
        cmp_state(state, q_state.pop_front());
        done_seen <= 1'b1;
      end
      if (done_seen === 1'b1 && idn !== 1'b0) cmp_bits(32'(idn), 32'h0);
      if (req_d !== 1'b1 && park_req === 1'b1) cmp_state(state, q_state.pop_front());
    end
    idn_d <= idn;
    req_d <= park_req;
  end

  // read command and address go out first, MSB first
  always @(posedge sclk or posedge csn) begin
    if (csn !== 1'b0) begin
      nbit <= 0;
    end else begin
      hdr <= {hdr[30:0], mosi};
      nbit <= nbit + 1;
      if (nbit == 31) cmp_bits({hdr[30:0], mosi}, q_word.pop_front());
    end
  end

  // flash must not be selected before the PLL has locked
  always @(negedge csn) begin
    if (resetn === 1'b1) cmp_bits(32'(locked), 32'h1);
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    lock_dly = 8'($urandom(64125) % 100);
    park_dly = 16'($urandom % 500 + 2);
    // clean power-up, then a warning while running
    do_reset();
    q_state.push_back(DPIS_ST_RUN);
    wait_for(0, 10000);
    cmp_bits(32'({pll_en, mpe, ldo, lsel}), 32'h1c);
    q_state.push_back(DPIS_ST_PARK);
    pg = 1'b0;
    wait_for(2, 4);
    wait_for(1, 10100);
    cmp_bits(32'({mpe, ldo}), 32'h0);
    repeat (10000) @(negedge clk); // reset held off while the clock runs
    cmp_state(state, DPIS_ST_PARKED);
    // warning in mid-load, mirror never reports done: window runs out
    lock_lock: begin
      lock_dly = 8'($urandom % 100);
      park_dly = 16'hffff;
      do_reset();
      repeat (300) @(negedge clk);
      q_state.push_back(DPIS_ST_PARK);
      pg = 1'b0;
      wait_for(2, 4);
      wait_for(1, 10100);
      cmp_bits(32'({idn, mpe}), 32'h2);
    end
    // power-up again after a park
    park_dly = 16'h0003;
    do_reset();
    q_state.push_back(DPIS_ST_RUN);
    wait_for(0, 10000);
    repeat (20) @(negedge clk);
    results();
  end
endmodule
